// ---- hw/ssp_pkg.sv ----
package ssp_pkg;

	// Register indices as printed, byte address is four times the index
	localparam logic [31:0] SSP_DATA_IDX  = 32'h0000_00fd;
	localparam logic [31:0] SSP_CTRL_IDX  = 32'h0000_00fe;
	localparam logic [31:0] SSP_DATA_ADDR = SSP_DATA_IDX << 2;
	localparam logic [31:0] SSP_CTRL_ADDR = SSP_CTRL_IDX << 2;

	// Control register field positions
	localparam int SSP_EN_BIT   = 7;
	localparam int SSP_TW_BIT   = 6;
	localparam int SSP_ARB_BIT  = 5;
	localparam int SSP_BUSY_BIT = 4;
	localparam int SSP_CPOL_BIT = 3;
	localparam int SSP_CPHA_BIT = 2;
	localparam int SSP_RATE_HI  = 1;
	localparam int SSP_RATE_LO  = 0;

	// Reset values
	localparam logic [7:0] SSP_CTRL_RST = 8'h00;
	localparam logic [7:0] SSP_DATA_RST = 8'h00;

	// Shift clock dividers of the core clock, per rate code
	localparam logic [8:0] SSP_DIV_R0 = 9'h008;
	localparam logic [8:0] SSP_DIV_R1 = 9'h010;
	localparam logic [8:0] SSP_DIV_R2 = 9'h080;
	localparam logic [8:0] SSP_DIV_R3 = 9'h100;
	localparam logic [7:0] SSP_HALF_R0 = SSP_DIV_R0[8:1];
	localparam logic [7:0] SSP_HALF_R1 = SSP_DIV_R1[8:1];
	localparam logic [7:0] SSP_HALF_R2 = SSP_DIV_R2[8:1];
	localparam logic [7:0] SSP_HALF_R3 = SSP_DIV_R3[8:1];

	// Sixteen clock half periods make one byte
	localparam logic [3:0] SSP_LAST_HALF = 4'hf;
	localparam logic [1:0] SSP_FIFO_DEPTH = 2'h2;
	localparam logic [1:0] SSP_HTRANS_NONSEQ = 2'h2;

	typedef enum logic {SSP_IDLE, SSP_SHIFT} ssp_state_e;

endpackage : ssp_pkg

// ---- hw/ssp_master.sv ----
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
module ssp_master import ssp_pkg::*; (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Serial pins
	output logic             sck_out,
	output logic             sck_oe,
	input  wire logic        sck_in,
	output logic             sdo_out,
	output logic             sdo_oe,
	input  wire logic        sdi_in,
	// Shared interrupt channel
	input  wire logic        ext_irq_pin,
	output logic             irq_chan2
);

	ssp_state_e state_q, state_d;
	logic       en_q, en_d, tw_q, tw_d, cpol_q, cpol_d, cpha_q, cpha_d;
	logic [1:0] rate_q, rate_d;
	logic       arb_q, arb_d, pend_q, pend_d, out_q, out_d, samp_q, samp_d;
	logic       lvl_q, lvl_d, sdi_prev_q, irq_q, irq_d;
	logic [7:0] tx_q, tx_d, sh_q, sh_d, cnt_q, cnt_d, half;
	logic [3:0] halves_q, halves_d;
	logic       edge_now, lead, stretch, done, start, sample_edge;
	logic [7:0] push_data;
	// Bus phase state
	logic       ap_wr_q, ap_data_q, ap_ctrl_q;
	logic       wr_data, wr_ctrl, rd_data, take;
	logic [31:0] rdata_q, rdata_d;
	// Two-entry receive buffer
	logic [7:0] mem_q [2];
	logic [7:0] rbuf_q, rbuf_d;
	logic [1:0] count_q, count_d;
	logic       wptr_q, rptr_q, push_ready, pop;

	// Zero wait state slave, always OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = rdata_q;
	assign take      = hsel && hready && htrans == SSP_HTRANS_NONSEQ;
	assign wr_data   = ap_wr_q && ap_data_q;
	assign wr_ctrl   = ap_wr_q && ap_ctrl_q;
	assign rd_data   = take && !hwrite && haddr == SSP_DATA_ADDR;
	assign pop       = rd_data && count_q != 2'h0;
	assign push_ready = count_q != SSP_FIFO_DEPTH;

	// Read mux, decoded in the address phase and registered
	always_comb begin
		rdata_d = rdata_q;
		rbuf_d  = pop ? mem_q[rptr_q] : rbuf_q;
		if (take && !hwrite) begin
			rdata_d = 32'h0000_0000;
			if (haddr == SSP_DATA_ADDR) begin
				rdata_d[7:0] = (count_q != 2'h0) ? mem_q[rptr_q] : rbuf_q;
			end else if (haddr == SSP_CTRL_ADDR) begin
				rdata_d[7:0] = {en_q, tw_q, arb_q, state_q == SSP_SHIFT,
					cpol_q, cpha_q, rate_q};
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_wr_q   <= 1'b0;
			ap_data_q <= 1'b0;
			ap_ctrl_q <= 1'b0;
			rdata_q   <= 32'h0000_0000;
			rbuf_q    <= SSP_DATA_RST;
		end else begin
			ap_wr_q   <= take && hwrite;
			ap_data_q <= take && haddr == SSP_DATA_ADDR;
			ap_ctrl_q <= take && haddr == SSP_CTRL_ADDR;
			rdata_q   <= rdata_d;
			rbuf_q    <= rbuf_d;
		end
	end

	// Receive buffer; a full buffer holds off the next start
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_q <= 2'h0;
			wptr_q  <= 1'b0;
			rptr_q  <= 1'b0;
			mem_q   <= '{8'h00, 8'h00};
		end else begin
			count_q <= count_d;
			if (done && push_ready) begin
				mem_q[wptr_q] <= push_data;
				wptr_q        <= ~wptr_q;
			end
			if (pop) begin
				rptr_q <= ~rptr_q;
			end
		end
	end

	always_comb begin
		count_d = count_q + {1'b0, done && push_ready} - {1'b0, pop};
	end

	// Half period of the shift clock per rate code
	always_comb begin
		case (rate_q)
			2'h0: half = SSP_HALF_R0;
			2'h1: half = SSP_HALF_R1;
			2'h2: half = SSP_HALF_R2;
			default: half = SSP_HALF_R3;
		endcase
	end

	// Slave holds the open-drain clock low to slow the master down
	assign stretch  = tw_q && lvl_q ^ cpol_q && !sck_in;
	assign edge_now = state_q == SSP_SHIFT && cnt_q == 8'h00 && !stretch;
	assign lead     = !halves_q[0];
	assign sample_edge = edge_now && (lead ^ cpha_q);
	assign done     = edge_now && halves_q == SSP_LAST_HALF;
	assign start    = state_q == SSP_IDLE && en_q && pend_q && push_ready;
	assign push_data = {sh_q[6:0], cpha_q ? sdi_in : samp_q};

	// Control, shifter and arbitration flag
	always_comb begin
		state_d = state_q; en_d = en_q; tw_d = tw_q; cpol_d = cpol_q;
		cpha_d = cpha_q; rate_d = rate_q; arb_d = arb_q; pend_d = pend_q;
		tx_d = tx_q; sh_d = sh_q; cnt_d = cnt_q; halves_d = halves_q;
		out_d = out_q; samp_d = samp_q; lvl_d = lvl_q;
		if (wr_ctrl) begin
			en_d   = hwdata[SSP_EN_BIT];
			tw_d   = hwdata[SSP_TW_BIT];
			cpol_d = hwdata[SSP_CPOL_BIT];
			cpha_d = hwdata[SSP_CPHA_BIT];
			rate_d = hwdata[SSP_RATE_HI:SSP_RATE_LO];
			if (hwdata[SSP_ARB_BIT]) begin
				arb_d = 1'b0;
			end
		end
		if (wr_data && en_q && state_q == SSP_IDLE && !pend_q) begin
			pend_d = 1'b1;
			tx_d   = hwdata[7:0];
		end
		if (start) begin
			state_d  = SSP_SHIFT;
			pend_d   = 1'b0;
			sh_d     = tx_q;
			cnt_d    = half - 8'h01;
			halves_d = 4'h0;
			lvl_d    = 1'b0;
			out_d    = cpha_q ? out_q : tx_q[7];
		end else if (state_q == SSP_SHIFT && !stretch) begin
			cnt_d = cnt_q - 8'h01;
			if (edge_now) begin
				cnt_d    = half - 8'h01;
				halves_d = halves_q + 4'h1;
				lvl_d    = !lvl_q;
				if (sample_edge && tw_q && out_q && !sdi_in) begin
					arb_d = 1'b1;
				end
				if (lead && !cpha_q) begin
					samp_d = sdi_in;
				end else if (lead) begin
					out_d = sh_q[7];
				end else begin
					sh_d  = push_data;
					out_d = cpha_q ? out_q : sh_q[6];
				end
				if (done) begin
					state_d = SSP_IDLE;
					out_d   = 1'b1;
				end
			end
		end
		if (!en_q) begin
			state_d = SSP_IDLE;
			pend_d  = 1'b0;
			lvl_d   = 1'b0;
			out_d   = 1'b1;
		end
	end

	// Source select of the shared interrupt line
	always_comb begin
		if (en_q) begin
			irq_d = done;
		end else if (tw_q) begin
			irq_d = sck_in && sdi_prev_q != sdi_in;
		end else begin
			irq_d = ext_irq_pin;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= SSP_IDLE; en_q <= SSP_CTRL_RST[SSP_EN_BIT];
			tw_q <= SSP_CTRL_RST[SSP_TW_BIT]; cpol_q <= SSP_CTRL_RST[SSP_CPOL_BIT];
			cpha_q <= SSP_CTRL_RST[SSP_CPHA_BIT]; rate_q <= 2'h0;
			arb_q <= 1'b0; pend_q <= 1'b0; tx_q <= SSP_DATA_RST; sh_q <= SSP_DATA_RST;
			cnt_q <= 8'h00; halves_q <= 4'h0; out_q <= 1'b1; samp_q <= 1'b0;
			lvl_q <= 1'b0; sdi_prev_q <= 1'b1; irq_q <= 1'b0;
		end else begin
			state_q <= state_d; en_q <= en_d; tw_q <= tw_d; cpol_q <= cpol_d;
			cpha_q <= cpha_d; rate_q <= rate_d; arb_q <= arb_d; pend_q <= pend_d;
			tx_q <= tx_d; sh_q <= sh_d; cnt_q <= cnt_d; halves_q <= halves_d;
			out_q <= out_d; samp_q <= samp_d; lvl_q <= lvl_d;
			sdi_prev_q <= sdi_in; irq_q <= irq_d;
		end
	end

	// Pins; in two-wire mode both lines only pull low
	assign sck_out   = tw_q ? 1'b0 : lvl_q ^ cpol_q;
	assign sck_oe    = en_q && (!tw_q || !(lvl_q ^ cpol_q));
	assign sdo_out   = tw_q ? 1'b0 : out_q;
	assign sdo_oe    = en_q && (!tw_q || !out_q);
	assign irq_chan2 = irq_q;

	sequence s_wr_start;
		wr_data && en_q && state_q == SSP_IDLE && !pend_q && push_ready && !wr_ctrl;
	endsequence

	sequence s_gap4;
		!edge_now [*3] ##1 edge_now;
	endsequence

	property p_no_clk_off;
		@(posedge hclk) disable iff (!hresetn) !en_q |-> !sck_oe ##1 state_q == SSP_IDLE;
	endproperty
	a_no_clk_off: assert property (p_no_clk_off) else $error("clock driven while off");

	property p_msb_first;
		@(posedge hclk) disable iff (!hresetn)
			start && !cpha_q && !tw_q |=> sdo_out == $past(tx_q[7]);
	endproperty
	a_msb_first: assert property (p_msb_first) else $error("first bit not MSB");

	property p_eight_clocks;
		@(posedge hclk) disable iff (!hresetn)
			done |-> halves_q == SSP_LAST_HALF ##1 state_q == SSP_IDLE && !lvl_q;
	endproperty
	a_eight_clocks: assert property (p_eight_clocks) else $error("byte length wrong");

	property p_busy_read;
		@(posedge hclk) disable iff (!hresetn)
			take && !hwrite && haddr == SSP_CTRL_ADDR
			|=> hrdata[SSP_BUSY_BIT] == $past(state_q == SSP_SHIFT);
	endproperty
	a_busy_read: assert property (p_busy_read) else $error("busy bit wrong");

	property p_idle_pol;
		@(posedge hclk) disable iff (!hresetn)
			state_q == SSP_IDLE && en_q && !tw_q |-> sck_out == cpol_q;
	endproperty
	a_idle_pol: assert property (p_idle_pol) else $error("idle level wrong");

	property p_rate_fast;
		@(posedge hclk) disable iff (!hresetn || !en_q)
			edge_now && !done && rate_q == 2'h0 && !tw_q |=> s_gap4;
	endproperty
	a_rate_fast: assert property (p_rate_fast) else $error("rate 0 gap wrong");

	property p_stretch;
		@(posedge hclk) disable iff (!hresetn)
			stretch && state_q == SSP_SHIFT && en_q && !start |=> $stable(cnt_q);
	endproperty
	a_stretch: assert property (p_stretch) else $error("stretch ignored");

	property p_irq_done;
		@(posedge hclk) disable iff (!hresetn) en_q && done |=> irq_chan2;
	endproperty
	a_irq_done: assert property (p_irq_done) else $error("no end interrupt");

	property p_irq_pin;
		@(posedge hclk) disable iff (!hresetn)
			!en_q && !tw_q |=> irq_chan2 == $past(ext_irq_pin);
	endproperty
	a_irq_pin: assert property (p_irq_pin) else $error("pin not passed");

	property p_write_start;
		@(posedge hclk) disable iff (!hresetn || !en_q) s_wr_start |=> pend_q ##1 state_q == SSP_SHIFT;
	endproperty
	a_write_start: assert property (p_write_start) else $error("write did not start");

endmodule : ssp_master

// ---- verif/ssp_periph_model.sv ----
`timescale 1ns/1ps
// Behavioural peripheral on the far side of the serial pins
module ssp_periph_model (
	// Clock
	input  wire logic       hclk,
	// Serial lines
	input  wire logic       sck,
	input  wire logic       serial_out_line,
	output logic            serial_in_line,
	// Mode and byte to answer with
	input  wire logic       cpol,
	input  wire logic       cpha,
	input  wire logic       load,
	input  wire logic [7:0] tx,
	output logic      [7:0] rx
);
	logic [7:0] sh_q;
	logic       prev_q;
	// Data line as it stood at the clock edge itself
	logic       sdo_q;
	logic       first_q;
	logic       lead;
	logic       samp;
	logic       drv;

	// Edge class follows the idle level
	assign lead = (sck != prev_q) && (sck != cpol);
	assign samp = (sck != prev_q) && (lead ^ cpha);
	assign drv  = (sck != prev_q) && !(lead ^ cpha);
	assign serial_in_line  = sh_q[7];

	// The freed LSB refills with the inverse of the old LSB, so a stale bit never looks valid
	always_ff @(posedge hclk) begin
		prev_q <= sck;
		sdo_q  <= serial_out_line;
		if (load) begin
			sh_q    <= tx;
			first_q <= 1'b1;
		end else begin
			if (samp) rx <= {rx[6:0], sdo_q};
			if (drv && !(first_q && cpha)) sh_q <= {sh_q[6:0], !sh_q[0]};
			if (drv) first_q <= 1'b0;
		end
	end
endmodule : ssp_periph_model

// ---- verif/tb.sv ----
`timescale 1ns/1ps
// Self-checking bench for the serial shift port master
module tb;
	import ssp_pkg::*;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq_chan2, ext_irq_pin;
	logic        sck_out, sck_oe, sdo_out, sdo_oe, serial_in_line, sck_w, sdo_w, m_cpol, m_cpha, p_load;
	logic        m_tw, sck_hold, sda_w, din_w;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata, rd, seed;
	logic [7:0]  p_tx, p_rx;
	int          n_errors, cmp_count, n;
	int          q[$];
	int          dq[$];
	int          dv[4] = '{8, 16, 128, 256};

	// Pull-ups hold both lines high when released
	assign sck_w = (sck_oe ? sck_out : 1'b1) && !sck_hold;
	assign sdo_w = sdo_oe ? sdo_out : 1'b1;
	// Two-wire mode joins data out and in on one wired-AND line
	assign sda_w = sdo_w && (serial_in_line || !m_tw);
	assign din_w = m_tw ? sda_w : serial_in_line;

	ssp_master i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sck_out(sck_out),
		.sck_oe(sck_oe), .sck_in(sck_w), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .sdi_in(din_w),
		.ext_irq_pin(ext_irq_pin), .irq_chan2(irq_chan2));
	ssp_periph_model i_per (.hclk(hclk), .sck(sck_w), .serial_out_line(sda_w), .serial_in_line(serial_in_line), .cpol(m_cpol),
		.cpha(m_cpha), .load(p_load), .tx(p_tx), .rx(p_rx));

	// 25 MHz core clock
	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic test_done();
		$display("Checks %0d, errors %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : test_done

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	// Bounded wait for hready at the next edges
	task automatic rdy();
		int k;
		k = 0;
		do begin
			@(posedge hclk);
			k++;
		end while (hreadyout !== 1'b1 && k < 50);
		if (k >= 50) begin
			n_errors++;
			test_done();
		end
	endtask : rdy

	// Single word transfer, read data lands in rd
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= SSP_HTRANS_NONSEQ;
		hwrite <= w;
		rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		rdy();
		rd = hrdata;
	endtask : ahb

	// Counts cycles into n until the end-of-byte pulse
	task automatic wirq();
		do begin
			@(posedge hclk);
			n++;
		end while (irq_chan2 !== 1'b1 && n < 5000);
		if (n >= 5000) begin
			n_errors++;
			test_done();
		end
		// One more edge lets the partner take its last bit
		@(posedge hclk);
	endtask : wirq

	// Loads the peripheral and writes a random byte to send
	task automatic st();
		logic [7:0] d;
		logic [7:0] t;
		d = 8'(xs());
		t = 8'(xs());
		p_tx <= t;
		p_load <= 1'b1;
		q.push_back(t);
		dq.push_back(d);
		ahb(1'b1, SSP_DATA_ADDR, {24'h0, d});
		p_load <= 1'b0;
	endtask : st

	task automatic xfer(input logic [7:0] c);
		st();
		repeat (4) @(posedge hclk);
		ahb(1'b0, SSP_CTRL_ADDR, 32'h0);
		chk("busy", rd, {24'h0, c | 8'h10});
		n = 6;
		wirq();
		chk("duration", 32'(n >= 8 * dv[c[1:0]] && n <= 8 * dv[c[1:0]] + 8), 32'h1);
		chk("slave rx", {24'h0, p_rx}, dq.pop_front());
	endtask : xfer

	initial begin
		logic [7:0] c, td, dd;
		{hresetn, hsel, hwrite, ext_irq_pin, m_cpol, m_cpha, p_load} = 7'h0;
		{m_tw, sck_hold} = 2'h0;
		{haddr, hwdata, htrans, p_tx} = '0;
		seed = 32'h5c5c;
		n_errors = 0;
		cmp_count = 0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		ahb(1'b0, SSP_CTRL_ADDR, 32'h0);
		chk("ctrl reset", rd, {24'h0, SSP_CTRL_RST});
		chk("hresp", {31'h0, hresp}, 32'h0);
		// Unmapped place keeps nothing
		ahb(1'b1, SSP_CTRL_ADDR + 32'h4, 32'hff);
		ahb(1'b0, SSP_CTRL_ADDR + 32'h4, 32'h0);
		chk("unmapped", rd, 32'h0);
		// Disabled port ignores a data write
		ahb(1'b1, SSP_DATA_ADDR, 32'ha5);
		repeat (8) @(posedge hclk);
		ahb(1'b0, SSP_CTRL_ADDR, 32'h0);
		chk("disabled", rd, 32'h0);
		ext_irq_pin <= 1'b1;
		repeat (3) @(posedge hclk);
		chk("pin irq", {31'h0, irq_chan2}, 32'h1);
		ext_irq_pin <= 1'b0;
		// Every rate code with a spread of clock modes
		for (int i = 0; i < 8; i++) begin
			c = {1'b1, 3'b000, i[2], i[0] ^ i[2], i[1:0]};
			m_cpol <= c[3];
			m_cpha <= c[2];
			ahb(1'b1, SSP_CTRL_ADDR, {24'h0, c});
			xfer(c);
			ahb(1'b0, SSP_CTRL_ADDR, 32'h0);
			chk("idle", rd, {24'h0, c});
			ahb(1'b0, SSP_DATA_ADDR, 32'h0);
			chk("rx byte", rd, q.pop_front());
		end
		// Two unread bytes fill the buffer and hold off a third start
		m_cpol <= 1'b0;
		m_cpha <= 1'b0;
		ahb(1'b1, SSP_CTRL_ADDR, 32'h80);
		xfer(8'h80);
		xfer(8'h80);
		st();
		n = 0;
		repeat (150) begin
			@(posedge hclk);
			if (irq_chan2 === 1'b1) n++;
		end
		chk("held start", 32'(n), 32'h0);
		ahb(1'b0, SSP_DATA_ADDR, 32'h0);
		chk("rx first", rd, q.pop_front());
		n = 0;
		wirq();
		chk("slave rx late", {24'h0, p_rx}, dq.pop_front());
		repeat (2) begin
			ahb(1'b0, SSP_DATA_ADDR, 32'h0);
			chk("rx drain", rd, q.pop_front());
		end
		// Two-wire mode; the bench holds the clock low for a while
		m_tw <= 1'b1;
		ahb(1'b1, SSP_CTRL_ADDR, 32'hc0);
		st();
		sck_hold <= 1'b1;
		repeat (40) @(posedge hclk);
		sck_hold <= 1'b0;
		n = 40;
		wirq();
		chk("stretch", 32'(n >= 8 * 8 + 30), 32'h1);
		td = 8'(q.pop_front());
		dd = 8'(dq.pop_front());
		chk("tw slave rx", {24'h0, p_rx}, {24'h0, td & dd});
		ahb(1'b0, SSP_DATA_ADDR, 32'h0);
		chk("tw rx", rd, {24'h0, td & dd});
		// Lost arbitration where a sent one met a zero on the line
		ahb(1'b0, SSP_CTRL_ADDR, 32'h0);
		chk("arb lost", rd, {24'h0, 8'hc0 | {2'h0, |(dd & ~td), 5'h0}});
		ahb(1'b1, SSP_CTRL_ADDR, 32'he0);
		ahb(1'b0, SSP_CTRL_ADDR, 32'h0);
		chk("arb clear", rd, 32'hc0);
		// Disabled two-wire port flags a data change under a high clock
		ahb(1'b1, SSP_CTRL_ADDR, 32'h40);
		p_tx <= 8'h00;
		p_load <= 1'b1;
		repeat (3) @(posedge hclk);
		p_tx <= 8'h80;
		n = 0;
		repeat (5) begin
			@(posedge hclk);
			p_load <= 1'b0;
			if (irq_chan2 === 1'b1) n++;
		end
		chk("start stop irq", 32'(n), 32'h1);
		test_done();
	end
endmodule : tb
